// file: hdl/air_cipher_pkg.sv
// Constants, register map and types for the air frame key stream cipher
package air_cipher_pkg;

  // Field and key stream geometry
  localparam int unsigned TAIL_BITS = 40;
  localparam int unsigned B_BITS    = 320;
  localparam int unsigned SEG_BITS  = 360;
  localparam int unsigned KS_BITS   = 720;
  localparam int unsigned B_KS_OFS  = 40;
  localparam int unsigned SINGLE_DATA_BITS = 304;
  localparam int unsigned MULTI_PERIOD     = 80;
  localparam int unsigned MULTI_DATA_BITS  = 64;
  localparam int unsigned CODEC_QUARTER    = 80;
  localparam logic [9:0]  SEG_LEN10 = 10'h168;
  localparam logic [9:0]  KS_LEN10  = 10'h2d0;
  localparam logic [3:0]  LBN_TOP   = 4'hf;

  // Start protocol
  localparam logic [2:0]  REQ_TRIES = 3'h5;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_KEY0   = 8'h08;
  localparam logic [7:0] OFS_KEY1   = 8'h0c;
  localparam logic [7:0] OFS_KEY2   = 8'h10;
  localparam logic [7:0] OFS_KEY3   = 8'h14;
  localparam logic [7:0] OFS_FRAME  = 8'h18;

  // Control register fields
  localparam int unsigned CTRL_START   = 0;
  localparam int unsigned CTRL_DEFKEY  = 1;
  localparam int unsigned CTRL_ADV     = 2;
  localparam int unsigned CTRL_DUPLEX  = 3;
  localparam int unsigned CTRL_LBN_LO  = 4;
  localparam int unsigned CTRL_RQ_LO   = 8;
  localparam int unsigned CTRL_KEY128  = 10;
  localparam logic [10:0] CTRL_RST     = 11'h008;

  // Status register fields
  localparam int unsigned ST_TXENC    = 3;
  localparam int unsigned ST_RXENC    = 4;
  localparam int unsigned ST_CONF     = 5;
  localparam int unsigned ST_REJ      = 6;
  localparam int unsigned ST_REL      = 7;
  localparam int unsigned ST_LATE     = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LAY_UNPROT  = 2'b00,
    LAY_SINGLE  = 2'b01,
    LAY_MULTI   = 2'b10,
    LAY_ENCODED = 2'b11
  } layout_t;

  typedef enum logic [1:0] {
    MT_START_REQ    = 2'b00,
    MT_START_GRANT  = 2'b01,
    MT_CIPHER_ON_CONFIRM   = 2'b10,
    MT_START_REJECT = 2'b11
  } mt_code_t;

  typedef enum logic [2:0] {
    S_CLEAR    = 3'b000,
    S_REQ      = 3'b001,
    S_GRANT    = 3'b010,
    S_ENC      = 3'b011,
    S_RELEASED = 3'b100
  } conn_state_t;

endpackage

// file: hdl/air_frame_keystream_cipher.sv
// Portable-side frame key stream cipher with start protocol and AXI4-Lite
module air_frame_keystream_cipher
  import air_cipher_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic                        s_axi_awvalid,
  output      logic                        s_axi_awready,
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_wvalid,
  output      logic                        s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  output      logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output      logic [1:0]                  s_axi_bresp,
  input  wire logic                        s_axi_arvalid,
  output      logic                        s_axi_arready,
  input  wire logic [7:0]                  s_axi_araddr,
  output      logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output      logic [31:0]                 s_axi_rdata,
  output      logic [1:0]                  s_axi_rresp,
  input  wire logic                        frame_tick,
  input  wire logic                        half_tick,
  input  wire logic [3:0]                  frame_num,
  input  wire logic [23:0]                 mframe_num,
  output      logic                        ksg_load,
  output      logic [34:0]                 init_vector,
  output      logic [127:0]                cipher_key,
  output      logic                        key_128,
  input  wire logic                        ks_valid,
  input  wire logic                        ks_bit,
  output      logic                        mt_send,
  output      air_cipher_pkg::mt_code_t    mt_code,
  input  wire logic                        mt_rx_valid,
  input  wire air_cipher_pkg::mt_code_t    mt_rx_code,
  input  wire logic                        fld_valid,
  input  wire logic                        fld_tx,
  input  wire logic                        fld_bearer,
  input  wire logic                        fld_tail_ctrl,
  input  wire air_cipher_pkg::layout_t     fld_layout,
  input  wire logic [39:0]                 fld_tail,
  input  wire logic [319:0]                fld_b,
  output      logic                        fld_out_valid,
  output      logic [39:0]                 fld_out_tail,
  output      logic [319:0]                fld_out_b,
  output      logic                        conn_release
);
  import air_cipher_pkg::*;

  // Payload bits of the B-field that take key stream bits
  function automatic logic [319:0] b_mask(layout_t l, logic [1:0] rq);
    logic [319:0] m;
    m = '0;
    for (int i = 0; i < B_BITS; i++) begin
      unique case (l)
        LAY_UNPROT:  m[i] = 1'b1;
        LAY_SINGLE:  m[i] = (i < SINGLE_DATA_BITS);
        LAY_MULTI:   m[i] = ((i % MULTI_PERIOD) < MULTI_DATA_BITS);
        LAY_ENCODED: m[i] = (i < CODEC_QUARTER * (int'(rq) + 1));
      endcase
    end
    return m;
  endfunction

  function automatic logic mapped(logic [7:0] a);
    return a == OFS_CTRL || a == OFS_STATUS || a == OFS_KEY0 ||
           a == OFS_KEY1 || a == OFS_KEY2 || a == OFS_KEY3 ||
           a == OFS_FRAME;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw,
                                        logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (st[k]) r[k*8 +: 8] = nw[k*8 +: 8];
    end
    return r;
  endfunction

  logic         aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [7:0]   awaddr_q;
  logic [31:0]  wdata_q, rdata_q, rd_d, ctrl_wr;
  logic [3:0]   wstrb_q;
  logic [1:0]   bresp_q, rresp_q;
  logic [10:0]  ctrl_q;
  logic [31:0]  key_q [4];
  logic         do_wr, start_cmd;
  conn_state_t  state_q;
  logic [2:0]   tries_q;
  logic         pend_q, tx_enc_q, rx_enc_q;
  logic         conf_q, rej_q, rel_q, late_q;
  logic [3:0]   frame_q;
  logic [23:0]  mframe_q;
  logic         even_start, cur_even, conf_ok, rej_ok, timeout;
  logic         send_req, send_grant;
  logic [9:0]   ks_cnt_q, ks_off;
  logic [359:0] seg_f_q, seg_p_q, seg_sel;
  logic         ks_full, enc_now, use_second;
  logic [319:0] bmask;
  logic [3:0]   clr_flags;

  // Register slave: address and data held until both are present
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign do_wr = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFS_CTRL:   rd_d = {21'h0, ctrl_q[10:1], 1'b0};
      OFS_STATUS: rd_d = {23'h0, late_q, rel_q, rej_q, conf_q, rx_enc_q,
                          tx_enc_q, state_q};
      OFS_KEY0:   rd_d = key_q[0];
      OFS_KEY1:   rd_d = key_q[1];
      OFS_KEY2:   rd_d = key_q[2];
      OFS_KEY3:   rd_d = key_q[3];
      OFS_FRAME:  rd_d = {4'h0, mframe_q, frame_q};
      default:    rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_d;
      rresp_q  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Control and key registers; start is a self-clearing command bit
  assign ctrl_wr   = merge({21'h0, ctrl_q}, wdata_q, wstrb_q);
  assign start_cmd = do_wr && awaddr_q == OFS_CTRL && wstrb_q[0] &&
                     wdata_q[CTRL_START];
  assign clr_flags = (do_wr && awaddr_q == OFS_STATUS) ?
                     (wdata_q[8:5] & {wstrb_q[1], {3{wstrb_q[0]}}}) : 4'h0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      for (int k = 0; k < 4; k++) key_q[k] <= 32'h0000_0000;
    end else if (do_wr) begin
      unique case (awaddr_q)
        OFS_CTRL: ctrl_q <= {ctrl_wr[10:1], 1'b0};
        OFS_KEY0: key_q[0] <= merge(key_q[0], wdata_q, wstrb_q);
        OFS_KEY1: key_q[1] <= merge(key_q[1], wdata_q, wstrb_q);
        OFS_KEY2: key_q[2] <= merge(key_q[2], wdata_q, wstrb_q);
        OFS_KEY3: key_q[3] <= merge(key_q[3], wdata_q, wstrb_q);
        default:  ;
      endcase
    end
  end

  // Short key zero-fills the top half so the generator sees bit 0 as LSB
  assign key_128    = ctrl_q[CTRL_KEY128];
  assign cipher_key = key_128 ? {key_q[3], key_q[2], key_q[1], key_q[0]}
                              : {64'h0, key_q[1], key_q[0]};

  // Frame numbering and start protocol
  assign even_start = frame_tick && !frame_num[0];
  assign cur_even   = !frame_q[0];
  assign conf_ok    = mt_rx_valid && mt_rx_code == MT_CIPHER_ON_CONFIRM &&
                      state_q == S_REQ && !cur_even;
  // Reject only counts when the request named the default key
  assign rej_ok     = mt_rx_valid && mt_rx_code == MT_START_REJECT &&
                      state_q == S_REQ && !cur_even &&
                      ctrl_q[CTRL_DEFKEY];
  assign timeout    = state_q == S_REQ && even_start &&
                      tries_q == REQ_TRIES && !conf_ok && !rej_ok;
  assign send_req   = half_tick && cur_even && state_q == S_REQ &&
                      tries_q != REQ_TRIES;
  assign send_grant = half_tick && cur_even && state_q == S_GRANT &&
                      tx_enc_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_q  <= 4'h0;
      mframe_q <= 24'h00_0000;
    end else if (frame_tick) begin
      frame_q  <= frame_num;
      mframe_q <= mframe_num;
    end
  end

  // One mode register serves every bearer of the connection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= S_CLEAR;
      tries_q  <= 3'h0;
      pend_q   <= 1'b0;
      tx_enc_q <= 1'b0;
      rx_enc_q <= 1'b0;
    end else begin
      unique case (state_q)
        S_CLEAR, S_RELEASED: begin
          if (start_cmd) pend_q <= 1'b1;
          if (pend_q && even_start) begin
            state_q <= S_REQ;
            tries_q <= 3'h0;
            pend_q  <= 1'b0;
          end
        end
        S_REQ: begin
          if (send_req) tries_q <= tries_q + 3'h1;
          if (conf_ok) begin
            // Frame carrying the confirm is already deciphered
            state_q  <= S_GRANT;
            rx_enc_q <= 1'b1;
          end else if (rej_ok) begin
            state_q <= S_CLEAR;
          end else if (timeout) begin
            state_q <= S_RELEASED;
          end
        end
        S_GRANT: begin
          if (even_start) tx_enc_q <= 1'b1;
          if (send_grant) state_q <= S_ENC;
        end
        S_ENC: state_q <= S_ENC;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mt_send      <= 1'b0;
      mt_code      <= MT_START_REQ;
      conn_release <= 1'b0;
    end else begin
      mt_send      <= send_req || send_grant;
      conn_release <= timeout;
      if (send_req) mt_code <= MT_START_REQ;
      else if (send_grant) mt_code <= MT_START_GRANT;
    end
  end

  // Sticky status: a new event in the clearing cycle survives
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conf_q <= 1'b0;
      rej_q  <= 1'b0;
      rel_q  <= 1'b0;
      late_q <= 1'b0;
    end else begin
      conf_q <= conf_ok || (conf_q && !clr_flags[0]);
      rej_q  <= rej_ok || (rej_q && !clr_flags[1]);
      rel_q  <= timeout || (rel_q && !clr_flags[2]);
      late_q <= (fld_valid && enc_now && !ks_full) ||
                (late_q && !clr_flags[3]);
    end
  end

  // Generator reload with a fresh vector for each ciphered or requesting frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ksg_load    <= 1'b0;
      init_vector <= 35'h0_0000_0000;
    end else begin
      // Requesting frames load too: the confirm frame arrives ciphered
      ksg_load <= frame_tick &&
                  (tx_enc_q || rx_enc_q || state_q == S_REQ);
      if (frame_tick) begin
        init_vector <= {3'h0,
                        ctrl_q[CTRL_ADV] ?
                          LBN_TOP - ctrl_q[CTRL_LBN_LO +: 4] : 4'h0,
                        mframe_num, frame_num};
      end
    end
  end

  // Collect the 720 generator bits of a frame into two segments
  assign ks_full = ks_cnt_q == KS_LEN10;
  assign ks_off  = ks_cnt_q - SEG_LEN10;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ks_cnt_q <= 10'h000;
      seg_f_q  <= '0;
      seg_p_q  <= '0;
    end else if (ksg_load) begin
      ks_cnt_q <= 10'h000;
    end else if (ks_valid && !ks_full) begin
      ks_cnt_q <= ks_cnt_q + 10'h001;
      if (ks_cnt_q < SEG_LEN10) seg_f_q[ks_cnt_q[8:0]] <= ks_bit;
      else seg_p_q[ks_off[8:0]] <= ks_bit;
    end
  end

  // Field XOR: duplex gives each direction its own segment; double simplex lets the bearer pick
  assign enc_now    = fld_tx ? tx_enc_q : rx_enc_q;
  assign use_second = ctrl_q[CTRL_DUPLEX] ? fld_tx : fld_bearer;
  assign seg_sel    = use_second ? seg_p_q : seg_f_q;
  // Mixed-content fields arrive flagged as multisubfield
  assign bmask      = b_mask(fld_layout, ctrl_q[CTRL_RQ_LO +: 2]);

  // Result feeds the check generators, so checks cover ciphered bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fld_out_valid <= 1'b0;
      fld_out_tail  <= 40'h00_0000_0000;
      fld_out_b     <= '0;
    end else begin
      fld_out_valid <= fld_valid;
      if (fld_valid) begin
        fld_out_tail <= (enc_now && fld_tail_ctrl) ?
                        fld_tail ^ seg_sel[39:0] : fld_tail;
        fld_out_b <= enc_now ?
                     fld_b ^ (seg_sel[359:40] & bmask) : fld_b;
      end
    end
  end

  sequence s_confirm;
    mt_rx_valid && mt_rx_code == MT_CIPHER_ON_CONFIRM && state_q == S_REQ &&
    frame_q[0];
  endsequence

  sequence s_grant_half;
    state_q == S_GRANT && tx_enc_q && half_tick && !frame_q[0];
  endsequence

  chk_tail_clear_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fld_valid && !fld_tail_ctrl |=> fld_out_tail == $past(fld_tail))
    else $error("non-control tail altered");
  chk_multi_gap_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fld_valid && fld_layout == LAY_MULTI |=>
    fld_out_b[79:64] == $past(fld_b[79:64]) &&
    fld_out_b[319:304] == $past(fld_b[319:304]))
    else $error("subfield check bits altered");
  chk_single_top_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fld_valid && fld_layout == LAY_SINGLE |=>
    fld_out_b[319:304] == $past(fld_b[319:304]))
    else $error("single layout check bits altered");
  chk_unprot_first_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fld_valid && fld_layout == LAY_UNPROT && rx_enc_q && !fld_tx &&
    ctrl_q[CTRL_DUPLEX] |=>
    fld_out_b[0] == ($past(fld_b[0]) ^ seg_f_q[40]))
    else $error("data bit 0 not paired with segment bit 40");
  chk_clear_passthru: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fld_valid && !tx_enc_q && !rx_enc_q |=>
    fld_out_b == $past(fld_b) && fld_out_tail == $past(fld_tail))
    else $error("clear mode altered a field");
  chk_load_per_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_tick && (tx_enc_q || rx_enc_q) |=>
    ksg_load && init_vector[3:0] == $past(frame_num) ##1
    ks_cnt_q == 10'h000)
    else $error("generator not reloaded with frame vector");
  chk_no_load_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q != S_REQ && !tx_enc_q && !rx_enc_q && !ksg_load |=> !ksg_load)
    else $error("generator loaded in clear mode");
  chk_vector_top_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ksg_load |-> init_vector[34:32] == 3'h0 &&
    (ctrl_q[CTRL_ADV] || init_vector[31:28] == 4'h0))
    else $error("vector upper bits not zero");
  chk_msg_even_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mt_send |-> !frame_q[0] && $past(half_tick))
    else $error("mode message outside even frame half");
  chk_req_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tries_q <= REQ_TRIES)
    else $error("more than five start requests");
  chk_confirm_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_confirm |=> rx_enc_q && state_q == S_GRANT)
    else $error("confirm did not start deciphering");
  chk_grant_sent: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_grant_half |=> mt_send && mt_code == MT_START_GRANT && state_q == S_ENC)
    else $error("grant not sent in even frame");

endmodule

// file: sim/air_frame_keystream_cipher_test.sv
// Bench for the air frame key stream cipher
module air_frame_keystream_cipher_test;
  timeunit 1ns;
  timeprecision 1ns;
  import air_cipher_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ksg_load, key_128, ks_valid, ks_bit, mt_send;
  logic mt_rx_valid, fld_out_valid, conn_release;
  logic frame_tick = 1'b0, half_tick = 1'b0, fld_valid = 1'b0;
  logic fld_tx = 1'b0, fld_tail_ctrl = 1'b0;
  logic fld_bearer = 1'b0, mute = 1'b0;
  int rq_n = 1;
  logic [3:0] frame_num = 4'h0;
  logic [9:0] cyc = 10'h000;
  logic [34:0] init_vector;
  logic [127:0] cipher_key;
  mt_code_t mt_code, mt_rx_code;
  layout_t fld_layout = LAY_UNPROT;
  logic [39:0] fld_tail = 40'h0, fld_out_tail;
  logic [319:0] fld_b = 320'h0, fld_out_b;
  int error_cnt = 0, cmp_count = 0;
  air_frame_keystream_cipher dut (
    .clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .frame_tick, .half_tick, .frame_num,
    .mframe_num(24'h5a3c1e), .ksg_load, .init_vector, .cipher_key,
    .key_128, .ks_valid, .ks_bit, .mt_send, .mt_code, .mt_rx_valid,
    .mt_rx_code, .fld_valid, .fld_tx, .fld_bearer, .fld_tail_ctrl,
    .fld_layout, .fld_tail, .fld_b, .fld_out_valid, .fld_out_tail,
    .fld_out_b, .conn_release);
  fixed_side_model peer (.clk_sys, .rst_n, .ksg_load, .mt_send, .mt_code,
    .frame_tick, .fn_odd(frame_num[0]), .mute, .ks_valid, .ks_bit,
    .mt_rx_valid, .mt_rx_code);
  initial forever #50 clk_sys = ~clk_sys;
  // Frame of 1000 cycles so all 720 key bits land before fields
  always @(posedge clk_sys) begin
    cyc <= (cyc == 10'h3e7) ? 10'h000 : cyc + 10'h001;
    frame_tick <= (cyc == 10'h3e7);
    half_tick <= (cyc == 10'h1f3);
    if (cyc == 10'h3e7) frame_num <= frame_num + 4'h1;
  end
  task automatic chk(input logic [319:0] seen, input logic [319:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk_sys);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      @(posedge clk_sys);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic msk(layout_t l, int i);
    case (l)
      LAY_UNPROT: return 1'b1;
      LAY_SINGLE: return 1'(i < SINGLE_DATA_BITS);
      LAY_MULTI:  return 1'((i % MULTI_PERIOD) < MULTI_DATA_BITS);
      default:    return 1'(i < CODEC_QUARTER * rq_n);
    endcase
  endfunction
  // Sec picks the second segment; in duplex that is the transmit side
  task automatic fld(input logic tx, tc, input layout_t l, input logic e,
                     input logic sec);
    logic [39:0] et;
    logic [319:0] eb;
    int b0;
    b0 = sec ? 360 : 0;
    et = 40'h3ca55a0ff0;
    eb = {10{32'h9e3779b9}};
    while (cyc !== 10'h384) @(posedge clk_sys);
    fld_valid <= 1'b1;
    fld_tx <= tx;
    fld_bearer <= sec;
    fld_tail_ctrl <= tc;
    fld_layout <= l;
    fld_tail <= et;
    fld_b <= eb;
    for (int j = 0; j < 40; j++) et[j] ^= e && tc && ((b0 + j) % 7 < 3);
    for (int j = 0; j < 320; j++)
      eb[j] ^= e && msk(l, j) && ((b0 + 40 + j) % 7 < 3);
    @(posedge clk_sys);
    fld_valid <= 1'b0;
    #1;
    chk(fld_out_valid, 1'b1);
    chk(fld_out_tail, et);
    chk(fld_out_b, eb);
    if (e) chk(init_vector, {7'h0c, 24'h5a3c1e, frame_num});
  endtask
  always @(posedge clk_sys)
    if (mt_send === 1'b1) chk({cyc, frame_num[0]}, 11'h3ea);
  initial begin
    repeat (45000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdr(OFS_CTRL);
    chk(rd, 32'h8);
    rdr(OFS_STATUS);
    chk(rd, 32'h0);
    rdr(8'h40);
    chk(rr, RESP_SLVERR);
    fld(1'b1, 1'b1, LAY_UNPROT, 1'b0, 1'b1);
    $display("test reset and clear done");
    for (int k = 0; k < 4; k++) wr(OFS_KEY0 + 8'(4 * k), 32'h13579bdf ^ k);
    wr(OFS_CTRL, 32'h43d);
    chk({key_128, cipher_key}, {1'b1, 128'h13579bdc13579bdd13579bde13579bdf});
    rdr(OFS_CTRL);
    chk(rd, 32'h43c);
    // Poll, since the switch waits for the frame exchange
    for (int k = 0; k < 60 && rd[2:0] !== 3'h3; k++) begin
      repeat (100) @(posedge clk_sys);
      rdr(OFS_STATUS);
    end
    chk(rd[7:0], 8'h3b);
    $display("test start done");
    for (int k = 0; k < 8; k++)
      fld(k[0], k[1] ^ k[0], layout_t'(k[2:1]), 1'b1, k[0]);
    // Double simplex: bearer picks the segment; codec at half rate
    wr(OFS_CTRL, 32'h534);
    rq_n = 2;
    fld(1'b0, 1'b1, LAY_ENCODED, 1'b1, 1'b1);
    fld(1'b1, 1'b0, LAY_MULTI, 1'b1, 1'b0);
    $display("test cipher done");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    mute <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(OFS_CTRL, 32'h9);
    for (int k = 0; k < 15000 && conn_release !== 1'b1; k++)
      @(posedge clk_sys);
    chk(conn_release, 1'b1);
    rdr(OFS_STATUS);
    chk(rd[7:0], 8'h84);
    $display("test release done");
    give_verdict();
  end
endmodule

// file: sim/fixed_side_model.sv
// Fixed side peer: key stream source and start confirm answers
module fixed_side_model
  import air_cipher_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     ksg_load,
  input  wire logic                     mt_send,
  input  wire air_cipher_pkg::mt_code_t mt_code,
  input  wire logic                     frame_tick,
  input  wire logic                     fn_odd,
  input  wire logic                     mute,
  output      logic                     ks_valid,
  output      logic                     ks_bit,
  output      logic                     mt_rx_valid,
  output      air_cipher_pkg::mt_code_t mt_rx_code
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt;
  logic req_q;
  // Two segments back to back after each load
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt <= 720;
    else if (ksg_load) cnt <= 0;
    else if (cnt < 720) cnt <= cnt + 1;
  end
  assign ks_valid = (cnt < 720);
  assign ks_bit   = ks_valid ? 1'((cnt % 7) < 3) : cnt[0];
  // Confirm early in each odd frame until grant seen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_q       <= 1'b0;
      mt_rx_valid <= 1'b0;
    end else begin
      // Mute plays a silent far end so the request limit is reached
      mt_rx_valid <= frame_tick && fn_odd && req_q && !mute;
      if (mt_send) req_q <= (mt_code == MT_START_REQ);
    end
  end
  assign mt_rx_code = MT_CIPHER_ON_CONFIRM;
endmodule
